// *** ltm_pkg.sv ***
// Constants for the limit timer: register map, fields, reset values, mode codes.
package ltm_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_MODE   = 8'h04;
  localparam logic [7:0] ADDR_PERIOD = 8'h08;
  localparam logic [7:0] ADDR_COUNT  = 8'h0c;
  localparam logic [7:0] ADDR_PWMCMP = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_MASK   = 8'h18;

  // ****************************************************************
  // Fields
  // ****************************************************************
  localparam int CTRL_ON_BIT  = 7;
  localparam int CTRL_PS_LSB  = 0;
  localparam int CTRL_PS_W    = 4;
  localparam int MODE_W       = 5;
  localparam int STAT_POST    = 0;
  localparam int STAT_EXTRST  = 1;
  localparam int STAT_W       = 2;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0]        PERIOD_RST = 8'hff;
  localparam logic [7:0]        COUNT_RST  = 8'h00;
  localparam logic [7:0]        PWMCMP_RST = 8'h00;
  localparam logic [CTRL_PS_W-1:0] PS_RST  = 4'h0;
  localparam logic [STAT_W-1:0] MASK_RST   = 2'h0;

  // ****************************************************************
  // Mode codes
  // ****************************************************************
  localparam logic [4:0] MODE_SWGATE    = 5'h00;
  localparam logic [4:0] MODE_GATE_HI   = 5'h01;
  localparam logic [4:0] MODE_GATE_LO   = 5'h02;
  localparam logic [4:0] MODE_RST_ANY   = 5'h03;
  localparam logic [4:0] MODE_RST_RISE  = 5'h04;
  localparam logic [4:0] MODE_RST_FALL  = 5'h05;
  localparam logic [4:0] MODE_RST_LOW   = 5'h06;
  localparam logic [4:0] MODE_RST_HIGH  = 5'h07;
  localparam logic [4:0] MODE_OS_SW     = 5'h08;
  localparam logic [4:0] MODE_OS_RISE   = 5'h09;
  localparam logic [4:0] MODE_OS_FALL   = 5'h0a;
  localparam logic [4:0] MODE_OS_ANY    = 5'h0b;
  localparam logic [4:0] MODE_OSR_RISE  = 5'h0c;
  localparam logic [4:0] MODE_OSR_FALL  = 5'h0d;
  localparam logic [4:0] MODE_OSL_RISE  = 5'h0e;
  localparam logic [4:0] MODE_OSL_FALL  = 5'h0f;
  localparam logic [4:0] MODE_MONO_RISE = 5'h11;
  localparam logic [4:0] MODE_MONO_FALL = 5'h12;
  localparam logic [4:0] MODE_MONO_ANY  = 5'h13;
  localparam logic [4:0] MODE_LVL_LOW   = 5'h16;
  localparam logic [4:0] MODE_LVL_HIGH  = 5'h17;

endpackage

// *** ltm_timer.sv ***
// Limit timer: 8-bit period counter with external start, gate and reset modes.
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/10ps

module ltm_timer (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  // Register port
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdata,
  // External pins
  input  wire logic       external_reset_input,
  input  wire logic       debugFreeze,
  // Timer outputs
  output logic      [7:0] count_value,
  output logic            postscaledPulse,
  output logic            pwmOut,
  output logic            timerIrq
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic       on_r;
  logic [3:0] postscale_select_r;
  logic [4:0] mode_r;
  logic [7:0] period_value_r;
  logic [7:0] count_r;
  logic [7:0] pulse_width_compare_r;
  logic [1:0] status_r;
  logic [1:0] timer_irq_enable_r;
  logic [7:0] rdata_r;
  logic [3:0] post_r;
  logic       postPulse_r;
  logic       pwm_r;
  logic       started_r;
  logic       onD1_r, onD2_r;
  logic       ersS1_r, ersS2_r, ersHeld_r, ersPrev_r;
  logic       frzS1_r, frzS2_r;

  logic wrCtrl, wrMode, wrCount;
  assign wrCtrl  = regWr && (regAddr == ltm_pkg::ADDR_CTRL);
  assign wrMode  = regWr && (regAddr == ltm_pkg::ADDR_MODE);
  assign wrCount = regWr && (regAddr == ltm_pkg::ADDR_COUNT);

  // ****************************************************************
  // Synchronisers
  // ****************************************************************
  // two-stage sync
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      onD1_r  <= 1'b0;
      onD2_r  <= 1'b0;
      ersS1_r <= 1'b0;
      ersS2_r <= 1'b0;
      frzS1_r <= 1'b0;
      frzS2_r <= 1'b0;
    end else begin
      onD1_r  <= on_r;
      onD2_r  <= onD1_r;
      ersS1_r <= external_reset_input;
      ersS2_r <= ersS1_r;
      frzS1_r <= debugFreeze;
      frzS2_r <= frzS1_r;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ersHeld_r <= 1'b0;
      ersPrev_r <= 1'b0;
    end else begin
      if (!frzS2_r) begin
        ersHeld_r <= ersS2_r;
      end
      ersPrev_r <= ersHeld_r;
    end
  end

  logic onEff, ersLvl, edgeRise, edgeFall, edgeAny;
  // Hardware clearing of the run bit must stop counting at once, not after the sync delay
  assign onEff    = on_r && onD2_r;
  assign ersLvl   = ersHeld_r;
  assign edgeRise = ersHeld_r && !ersPrev_r;
  assign edgeFall = !ersHeld_r && ersPrev_r;
  assign edgeAny  = edgeRise || edgeFall;

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  logic validMode, gateOk, needStart, startEv, rstLvl, rstEdge, oneShot, mono;
  always_comb begin
    validMode = 1'b1;
    gateOk    = 1'b1;
    needStart = 1'b0;
    startEv   = 1'b0;
    rstLvl    = 1'b0;
    rstEdge   = 1'b0;
    oneShot   = 1'b0;
    mono      = 1'b0;
    case (mode_r)
      ltm_pkg::MODE_SWGATE: begin
      end
      ltm_pkg::MODE_GATE_HI: gateOk = ersLvl;
      ltm_pkg::MODE_GATE_LO: gateOk = !ersLvl;
      ltm_pkg::MODE_RST_ANY:  rstEdge = edgeAny;
      ltm_pkg::MODE_RST_RISE: rstEdge = edgeRise;
      ltm_pkg::MODE_RST_FALL: rstEdge = edgeFall;
      ltm_pkg::MODE_RST_LOW:  rstLvl  = !ersLvl;
      ltm_pkg::MODE_RST_HIGH: rstLvl  = ersLvl;
      ltm_pkg::MODE_OS_SW:    oneShot = 1'b1;
      ltm_pkg::MODE_OS_RISE, ltm_pkg::MODE_OS_FALL, ltm_pkg::MODE_OS_ANY: begin
        oneShot   = 1'b1;
        needStart = 1'b1;
        startEv   = (mode_r == ltm_pkg::MODE_OS_RISE) ? edgeRise :
                    (mode_r == ltm_pkg::MODE_OS_FALL) ? edgeFall : edgeAny;
      end
      // Bit 0 of the code picks the falling-edge twin of each pair
      ltm_pkg::MODE_OSR_RISE, ltm_pkg::MODE_OSR_FALL: begin
        oneShot   = 1'b1;
        needStart = 1'b1;
        startEv   = mode_r[0] ? edgeFall : edgeRise;
        rstEdge   = started_r && startEv;
      end
      ltm_pkg::MODE_OSL_RISE, ltm_pkg::MODE_OSL_FALL: begin
        oneShot   = 1'b1;
        needStart = 1'b1;
        startEv   = mode_r[0] ? edgeFall : edgeRise;
        rstLvl    = mode_r[0] ? ersLvl : !ersLvl;
      end
      ltm_pkg::MODE_MONO_RISE, ltm_pkg::MODE_MONO_FALL, ltm_pkg::MODE_MONO_ANY: begin
        mono      = 1'b1;
        needStart = 1'b1;
        startEv   = (mode_r == ltm_pkg::MODE_MONO_RISE) ? edgeRise :
                    (mode_r == ltm_pkg::MODE_MONO_FALL) ? edgeFall : edgeAny;
      end
      ltm_pkg::MODE_LVL_LOW, ltm_pkg::MODE_LVL_HIGH: begin
        oneShot = 1'b1;
        rstLvl  = mode_r[0] ? ersLvl : !ersLvl;
      end
      default: validMode = 1'b0;
    endcase
  end

  logic running, resetNow, matchNow;
  assign resetNow = validMode && onEff && (rstLvl || rstEdge);
  assign running  = validMode && onEff && gateOk && !rstLvl && (!needStart || started_r);
  assign matchNow = running && (count_r == period_value_r);

  // ****************************************************************
  // Start tracking
  // ****************************************************************
  // fresh edge after run cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      started_r <= 1'b0;
    end else if (!onEff || wrMode || (matchNow && (oneShot || mono))) begin
      started_r <= 1'b0;
    end else if (needStart && startEv) begin
      started_r <= 1'b1;
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      on_r               <= 1'b0;
      postscale_select_r <= ltm_pkg::PS_RST;
    end else if (wrCtrl) begin
      on_r               <= regWdata[ltm_pkg::CTRL_ON_BIT];
      postscale_select_r <= regWdata[ltm_pkg::CTRL_PS_LSB +: ltm_pkg::CTRL_PS_W];
    end else if (matchNow && oneShot) begin
      on_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mode_r                <= ltm_pkg::MODE_SWGATE;
      period_value_r        <= ltm_pkg::PERIOD_RST;
      pulse_width_compare_r <= ltm_pkg::PWMCMP_RST;
      timer_irq_enable_r    <= ltm_pkg::MASK_RST;
    end else if (regWr) begin
      case (regAddr)
        ltm_pkg::ADDR_MODE:   mode_r                <= regWdata[ltm_pkg::MODE_W-1:0];
        ltm_pkg::ADDR_PERIOD: period_value_r        <= regWdata;
        ltm_pkg::ADDR_PWMCMP: pulse_width_compare_r <= regWdata;
        ltm_pkg::ADDR_MASK:   timer_irq_enable_r    <= regWdata[ltm_pkg::STAT_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Counter
  // ****************************************************************
  // wrap to zero on match
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      count_r <= ltm_pkg::COUNT_RST;
    end else if (wrCount) begin
      count_r <= regWdata;
    end else if (resetNow || matchNow) begin
      // monostable also lands at zero, stopped by the start flag
      count_r <= 8'h00;
    end else if (running) begin
      count_r <= count_r + 8'h01;
    end
  end

  // ****************************************************************
  // Postscaler
  // ****************************************************************
  // ratio of select plus one
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      post_r      <= 4'h0;
      postPulse_r <= 1'b0;
    end else begin
      postPulse_r <= 1'b0;
      if (wrCtrl || wrCount || resetNow) begin
        post_r <= 4'h0;
      end else if (matchNow) begin
        if (post_r == postscale_select_r) begin
          post_r      <= 4'h0;
          postPulse_r <= 1'b1;
        end else begin
          post_r <= post_r + 4'h1;
        end
      end
    end
  end

  // ****************************************************************
  // PWM time base
  // ****************************************************************
  // restart after reset
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pwm_r <= 1'b0;
    end else if (running && (count_r == pulse_width_compare_r)) begin
      pwm_r <= 1'b0;
    end else if (running && (count_r == 8'h00)) begin
      pwm_r <= 1'b1;
    end
  end

  // ****************************************************************
  // Interrupt status and read port
  // ****************************************************************
  wire logic [1:0] events = {resetNow, postPulse_r};

  // Set wins over a simultaneous write-one clear
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      status_r <= 2'h0;
    end else if (regWr && (regAddr == ltm_pkg::ADDR_STATUS)) begin
      status_r <= (status_r & ~regWdata[ltm_pkg::STAT_W-1:0]) | events;
    end else begin
      status_r <= status_r | events;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= 8'h00;
    end else if (regRd) begin
      case (regAddr)
        ltm_pkg::ADDR_CTRL:   rdata_r <= {on_r, 3'h0, postscale_select_r};
        ltm_pkg::ADDR_MODE:   rdata_r <= {3'h0, mode_r};
        ltm_pkg::ADDR_PERIOD: rdata_r <= period_value_r;
        ltm_pkg::ADDR_COUNT:  rdata_r <= count_r;
        ltm_pkg::ADDR_PWMCMP: rdata_r <= pulse_width_compare_r;
        ltm_pkg::ADDR_STATUS: rdata_r <= {6'h00, status_r};
        ltm_pkg::ADDR_MASK:   rdata_r <= {6'h00, timer_irq_enable_r};
        default:              rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign regRdata        = rdata_r;
  assign count_value     = count_r;
  assign postscaledPulse = postPulse_r;
  assign pwmOut          = pwm_r;
  assign timerIrq        = |(status_r & timer_irq_enable_r);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence s_runClear;
    !onEff ##1 onEff;
  endsequence

  a_irq_mask: assert property (timerIrq == |(status_r & timer_irq_enable_r))
    else $error("interrupt output does not follow masked status");
  a_oneshot_stop: assert property (matchNow && oneShot && !regWr |=> count_r == 8'h00 && !on_r)
    else $error("one-shot did not stop at zero with run bit cleared");
  a_mono_keep_on: assert property (matchNow && mono && !regWr |=> count_r == 8'h00 && on_r && !started_r)
    else $error("monostable did not stop with run bit kept");
  a_swgate_inc: assert property (mode_r == ltm_pkg::MODE_SWGATE && onEff && !matchNow && !regWr
      |=> count_r == $past(count_r) + 8'h01)
    else $error("software gate count did not increment");
  a_swgate_hold: assert property (mode_r == ltm_pkg::MODE_SWGATE && !onEff && !regWr |=> $stable(count_r))
    else $error("count moved while run bit clear");
  a_period_wrap: assert property (matchNow && !oneShot && !mono && !regWr && !resetNow
      |=> count_r == 8'h00 ##1 (count_r == 8'h01 || !running || regWr || !$past(running)
      || $past(resetNow) || $past(regWr) || $past(matchNow)))
    else $error("count did not wrap and resume after match");
  a_gate_hold: assert property (mode_r == ltm_pkg::MODE_GATE_HI && !ersLvl && !regWr |=> $stable(count_r))
    else $error("hardware gate did not hold count");
  a_edge_reset: assert property (mode_r == ltm_pkg::MODE_RST_RISE && onEff && edgeRise && !regWr
      |=> count_r == 8'h00)
    else $error("rising edge did not reset count");
  a_post_irq: assert property (postPulse_r |=> status_r[ltm_pkg::STAT_POST])
    else $error("postscaler pulse did not set status");
  a_fresh_edge: assert property (s_runClear ##0 needStart |-> !started_r)
    else $error("edge mode resumed without a new edge");
  a_on_sync: assert property ($rose(on_r) |-> !onEff ##1 !onEff)
    else $error("run bit took effect before two sync clocks");
  a_off_ignore: assert property (!on_r |-> !resetNow && !running)
    else $error("external input acted while run bit clear");
  a_freeze_ign: assert property (frzS2_r |=> $stable(ersHeld_r))
    else $error("external input moved during debug freeze");
  a_lvl_reset: assert property (mode_r == ltm_pkg::MODE_LVL_LOW && onEff && !ersLvl && !regWr
      |=> count_r == 8'h00)
    else $error("level one-shot not held in reset");
  a_read_lat: assert property (regRd && regAddr == ltm_pkg::ADDR_COUNT |=> regRdata == $past(count_r))
    else $error("read data wrong in cycle after strobe");

endmodule

// *** ltm_ers_source.sv ***
// Model of the peripheral that drives the timer's external reset input.
`timescale 1ns/10ps
module ltm_ers_source (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rstn,
  // Level requested by the bench
  input  wire logic wantLevel,
  // Pin towards the timer
  output logic      external_reset_input
);
  logic [3:0] sinceEdge_r;

  // edge spacing, level hold
  // A request that comes too soon is delayed, and dropped if withdrawn before six cycles since the last edge
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      external_reset_input <= 1'b0;
      sinceEdge_r          <= 4'h0;
    end else if (wantLevel != external_reset_input && sinceEdge_r >= 4'h6) begin
      external_reset_input <= wantLevel;
      sinceEdge_r          <= 4'h0;
    end else if (sinceEdge_r != 4'hf) begin
      sinceEdge_r <= sinceEdge_r + 4'h1;
    end
  end
endmodule

// *** ltm_timer_test.sv ***
// Self-checking testbench for the limit timer.
`timescale 1ns/10ps
module ltm_timer_test;
  logic       ref_clk;
  logic       rstn;
  logic [7:0] regAddr;
  logic [7:0] regWdata;
  logic       regWr;
  logic       regRd;
  logic [7:0] regRdata;
  logic       wantLevel;
  logic       external_reset_input;
  logic       debugFreeze;
  logic [7:0] count_value;
  logic       postscaledPulse;
  logic       pwmOut;
  logic       timerIrq;
  integer     num_errors;
  integer     n_tests;
  integer     seed;
  integer     i;
  integer     m;
  integer     gap;
  logic [7:0] rdv;
  logic [7:0] per;
  logic [7:0] prev;
  logic       pwmPrev;

  ltm_timer dut (
    .ref_clk              (ref_clk),
    .rstn                 (rstn),
    .regAddr              (regAddr),
    .regWdata             (regWdata),
    .regWr                (regWr),
    .regRd                (regRd),
    .regRdata             (regRdata),
    .external_reset_input (external_reset_input),
    .debugFreeze          (debugFreeze),
    .count_value          (count_value),
    .postscaledPulse      (postscaledPulse),
    .pwmOut               (pwmOut),
    .timerIrq             (timerIrq)
  );

  ltm_ers_source ers (
    .ref_clk              (ref_clk),
    .rstn                 (rstn),
    .wantLevel            (wantLevel),
    .external_reset_input (external_reset_input)
  );

  initial ref_clk = 1'b0;
  always #12.5 ref_clk = ~ref_clk;

  // ****************************************************************
  // Expectations and bus tasks
  // ****************************************************************
  function automatic logic [7:0] rstVal(input integer k);
    return (k == 2) ? ltm_pkg::PERIOD_RST : 8'h00;
  endfunction

  // Pulse is high from the count after zero up to and including the compare value
  function automatic logic [7:0] pwmExp(input logic [7:0] c, input logic [7:0] cmp);
    return {7'h0, (c != 8'h00) && (c <= cmp)};
  endfunction

  task automatic summarize;
    $display("Errors %0d of %0d checks", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic timeout;
    num_errors = num_errors + 1;
    $display("[ERR] %0t: wait limit reached", $time);
    summarize();
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic ticks(input integer n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask

  // Read data stand one cycle only, so they are taken mid-cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    @(negedge ref_clk);
    d = regRdata;
  endtask

  // Wait covers partner spacing plus the two sync stages
  task automatic lvl(input logic v);
    wantLevel <= v;
    ticks(9);
    @(negedge ref_clk);
  endtask

  task automatic runCheck(input integer n);
    @(negedge ref_clk);
    prev = count_value;
    repeat (n) begin
      @(negedge ref_clk);
      check(count_value, (prev == per) ? 8'h00 : prev + 8'h01);
      prev = count_value;
    end
  endtask

  task automatic holdCheck(input integer n);
    @(negedge ref_clk);
    prev    = count_value;
    pwmPrev = pwmOut;
    repeat (n) begin
      @(negedge ref_clk);
      check(count_value, prev);
      check({7'h0, pwmOut}, {7'h0, pwmPrev});
    end
  endtask

  task automatic waitPulse(output integer n);
    n = 0;
    do begin
      @(negedge ref_clk);
      n = n + 1;
    end while (postscaledPulse !== 1'b1 && n < 400);
    if (n >= 400) timeout();
  endtask

  task automatic waitOff;
    rdv = 8'h80;
    for (int k = 0; k < 80 && rdv[7] !== 1'b0; k++) rd(ltm_pkg::ADDR_CTRL, rdv);
    if (rdv[7] !== 1'b0) timeout();
  endtask

  initial begin
    repeat (60000) @(posedge ref_clk);
    timeout();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    seed        = 32'heb0deee6;
    num_errors  = 0;
    n_tests     = 0;
    rstn        = 1'b0;
    regAddr     = 8'h00;
    regWdata    = 8'h00;
    regWr       = 1'b0;
    regRd       = 1'b0;
    wantLevel   = 1'b0;
    debugFreeze = 1'b0;
    ticks(8);
    rstn <= 1'b1;
    for (i = 0; i < 8; i++) begin
      rd(8'(i * 4), rdv);
      check(rdv, rstVal(i)); // interrupt enable clear at reset
    end
    per = 8'h03 + 8'($random(seed) & 7);
    wr(ltm_pkg::ADDR_PERIOD, per);
    wr(ltm_pkg::ADDR_COUNT, 8'($random(seed) & 3));
    wr(ltm_pkg::ADDR_CTRL, 8'h80);
    ticks(3);
    runCheck(3 * per + 6);
    wr(ltm_pkg::ADDR_CTRL, 8'h00);
    holdCheck(6);
    wr(ltm_pkg::ADDR_PWMCMP, 8'h02);
    wr(ltm_pkg::ADDR_COUNT, 8'h00);
    wr(ltm_pkg::ADDR_CTRL, 8'h80);
    repeat (2 * per + 8) begin
      @(negedge ref_clk);
      check({7'h0, pwmOut}, pwmExp(count_value, 8'h02));
    end
    for (m = 0; m < 16; m++) begin
      wr(ltm_pkg::ADDR_CTRL, 8'h80 | 8'(m));
      waitPulse(gap);
      waitPulse(gap);
      check(8'(gap), 8'((per + 1) * (m + 1)));
    end
    wr(ltm_pkg::ADDR_CTRL, 8'h00);
    rd(ltm_pkg::ADDR_STATUS, rdv);
    check(rdv & 8'h01, 8'h01);
    check({7'h0, timerIrq}, 8'h00);
    wr(ltm_pkg::ADDR_MASK, 8'h01);
    @(negedge ref_clk);
    check({7'h0, timerIrq}, 8'h01);
    wr(ltm_pkg::ADDR_STATUS, 8'h03);
    @(negedge ref_clk);
    check({7'h0, timerIrq}, 8'h00);
    // Gate modes: the first level stops the count, the second lets it run
    for (m = 1; m <= 2; m++) begin
      wr(ltm_pkg::ADDR_MODE, 8'(m));
      wr(ltm_pkg::ADDR_CTRL, 8'h80);
      lvl(m == 2);
      holdCheck(6);
      lvl(m == 1);
      runCheck(8);
    end
    wr(ltm_pkg::ADDR_PERIOD, 8'hff);
    for (m = 3; m <= 5; m++) begin
      wr(ltm_pkg::ADDR_MODE, 8'(m));
      for (i = 1; i >= 0; i--) begin
        wr(ltm_pkg::ADDR_COUNT, 8'h40);
        lvl(i[0]);
        check({7'h0, count_value < 8'h10}, {7'h0, (i == 1) ? m != 5 : m != 4});
      end
    end
    wr(ltm_pkg::ADDR_CTRL, 8'h00);
    wr(ltm_pkg::ADDR_COUNT, 8'h40);
    lvl(1'b1);
    check(count_value, 8'h40);
    wr(ltm_pkg::ADDR_CTRL, 8'h80);
    debugFreeze <= 1'b1;
    ticks(3);
    wr(ltm_pkg::ADDR_COUNT, 8'h40);
    lvl(1'b0);
    check({7'h0, count_value < 8'h10}, 8'h00);
    debugFreeze <= 1'b0;
    wr(ltm_pkg::ADDR_PERIOD, 8'h05);
    wr(ltm_pkg::ADDR_MODE, 8'h08);
    wr(ltm_pkg::ADDR_COUNT, 8'h00);
    wr(ltm_pkg::ADDR_CTRL, 8'h80);
    waitOff();
    check(count_value, 8'h00);
    holdCheck(5);
    per = 8'hff;
    wr(ltm_pkg::ADDR_PERIOD, per);
    wr(ltm_pkg::ADDR_MODE, 8'h09);
    wr(ltm_pkg::ADDR_CTRL, 8'h80);
    lvl(1'b1);
    wr(ltm_pkg::ADDR_CTRL, 8'h00);
    wr(ltm_pkg::ADDR_CTRL, 8'h80);
    ticks(3);
    holdCheck(6);
    lvl(1'b0);
    lvl(1'b1);
    runCheck(8);
    wr(ltm_pkg::ADDR_PERIOD, 8'h20);
    for (m = 8'h11; m <= 8'h13; m++) begin
      wr(ltm_pkg::ADDR_CTRL, 8'h00);
      lvl(m == 8'h12);
      wr(ltm_pkg::ADDR_MODE, 8'(m));
      wr(ltm_pkg::ADDR_COUNT, 8'h00);
      wr(ltm_pkg::ADDR_CTRL, 8'h80);
      holdCheck(6);
      lvl(m != 8'h12);
      check({7'h0, count_value != 8'h00}, 8'h01);
      ticks(40);
      @(negedge ref_clk);
      check(count_value, 8'h00);
      rd(ltm_pkg::ADDR_CTRL, rdv);
      check(rdv & 8'h80, 8'h80);
    end
    wr(ltm_pkg::ADDR_CTRL, 8'h00);
    lvl(1'b0);
    wr(ltm_pkg::ADDR_MODE, 8'h16);
    wr(ltm_pkg::ADDR_CTRL, 8'h80);
    holdCheck(6);
    check(count_value, 8'h00);
    lvl(1'b1);
    check({7'h0, count_value != 8'h00}, 8'h01);
    waitOff();
    check(count_value, 8'h00);
    wr(ltm_pkg::ADDR_MODE, 8'h0e);
    lvl(1'b0);
    wr(ltm_pkg::ADDR_COUNT, 8'h07);
    wr(ltm_pkg::ADDR_CTRL, 8'h80);
    ticks(3);
    holdCheck(6);
    check(count_value, 8'h00);
    lvl(1'b1);
    check({7'h0, count_value != 8'h00}, 8'h01);
    waitOff();
    check(count_value, 8'h00);
    summarize();
  end
endmodule
